/* File: hdl/ssc_core.sv */
// Serial command front end of a byte-organised static memory.
// Assumes the master drives select, serial clock and data asynchronously to
// ref_clk, with its serial clock at least eight ref_clk periods long.
`timescale 1ns/1ps
module ssc_core
  import ssc_pkg::*;
#(
  parameter int ADDR_W = SSC_ADDR_BITS
) (
  input  wire logic ref_clk,          // Core clock, 125 MHz
  input  wire logic reset_n,          // Async reset, active low
  input  wire logic chipSelectN,      // Select pin, active low
  input  wire logic serialClk,        // Serial clock pin
  input  wire logic dualLineLowIn,    // Serial input / low data line in
  output logic      dualLineLowOut,   // Low data line out
  output logic      dualLineLowOe,    // Low data line drive enable
  input  wire logic dualLineHighIn,   // High data line in
  output logic      dualLineHighOut,  // Serial output / high data line out
  output logic      dualLineHighOe,   // High data line drive enable
  output logic      standby,          // Deselected and idle
  output logic      twoBitMode        // Two-bit-wide transfers active
);
  logic [SSC_PIN_COUNT-1:0] pinLvl;
  logic [SSC_PIN_COUNT-1:0] pinRise;
  logic [SSC_PIN_COUNT-1:0] pinFall;
  logic                     csHigh;
  logic                     sckRise;
  logic                     sckFall;

  ssc_state_t        state_reg;
  ssc_state_t        state_next;
  ssc_op_t           op_reg;
  ssc_op_t           op_next;
  logic [15:0]       shift_reg;
  logic [15:0]       shift_next;
  logic [4:0]        bitCnt_reg;
  logic [4:0]        bitCnt_next;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic [1:0]        mode_reg;
  logic [1:0]        mode_next;
  logic              wide_reg;
  logic              wide_next;
  logic [7:0]        outShift_reg;
  logic [7:0]        outShift_next;
  logic [3:0]        outCnt_reg;
  logic [3:0]        outCnt_next;
  logic              outHigh_reg;
  logic              outHigh_next;
  logic              outLow_reg;
  logic              outLow_next;
  logic              oeHigh_reg;
  logic              oeHigh_next;
  logic              oeLow_reg;
  logic              oeLow_next;

  logic [15:0]       shiftIn;
  logic [4:0]        bitsNext;
  logic [3:0]        outNext;
  logic [7:0]        byteNow;
  logic [7:0]        memRdata;
  logic              memWe;
  logic              isWrite;
  logic              isRead;

  // Select idles high, so it must not report a rise out of reset
  ssc_pin_sync #(
    .WIDTH    (SSC_PIN_COUNT)
  ) u_sync (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .pinIn    ({dualLineHighIn, dualLineLowIn, serialClk, chipSelectN}),
    .pinReset (4'h0),
    .level    (pinLvl),
    .rise     (pinRise),
    .fall     (pinFall)
  );

  ssc_mem #(
    .ADDR_W (ADDR_W)
  ) u_mem (
    .ref_clk (ref_clk),
    .wrEn    (memWe),
    .addr    (addr_reg),
    .wrData  (shiftIn[7:0]),
    .rdData  (memRdata)
  );

  assign csHigh  = pinLvl[SSC_CS_PIN];
  assign sckRise = pinRise[SSC_SCK_PIN];
  assign sckFall = pinFall[SSC_SCK_PIN];
  assign isWrite = (op_reg == SSC_OP_ARR_WR) || (op_reg == SSC_OP_MODE_WR);
  assign isRead  = !isWrite;

  // Page mode keeps the upper address bits, sequential mode lets them carry
  function automatic logic [ADDR_W-1:0] nextAddr(input logic [ADDR_W-1:0] a,
                                                 input logic [1:0]        m);
    logic [ADDR_W-1:0] inc;
    inc = a + 1'b1;
    if (m == SSC_MODE_PAGE) begin
      nextAddr = {a[ADDR_W-1:SSC_PAGE_BITS], inc[SSC_PAGE_BITS-1:0]};
    end else begin
      nextAddr = inc;
    end
  endfunction

  always_comb begin
    if (wide_reg) begin
      shiftIn  = {shift_reg[13:0], pinLvl[SSC_HIGH_PIN], pinLvl[SSC_LOW_PIN]};
      bitsNext = bitCnt_reg + 5'h2;
      outNext  = outCnt_reg + 4'h2;
    end else begin
      shiftIn  = {shift_reg[14:0], pinLvl[SSC_LOW_PIN]};
      bitsNext = bitCnt_reg + 5'h1;
      outNext  = outCnt_reg + 4'h1;
    end
  end

  always_comb begin
    if (outCnt_reg != 4'h0) begin
      byteNow = outShift_reg;
    end else if (op_reg == SSC_OP_MODE_RD) begin
      byteNow = {mode_reg, SSC_MODE_LOW_BITS};
    end else begin
      byteNow = memRdata;
    end
  end

  always_comb begin
    state_next    = state_reg;
    op_next       = op_reg;
    shift_next    = shift_reg;
    bitCnt_next   = bitCnt_reg;
    addr_next     = addr_reg;
    mode_next     = mode_reg;
    wide_next     = wide_reg;
    outShift_next = outShift_reg;
    outCnt_next   = outCnt_reg;
    outHigh_next  = outHigh_reg;
    outLow_next   = outLow_reg;
    oeHigh_next   = oeHigh_reg;
    oeLow_next    = oeLow_reg;
    memWe         = 1'b0;
    if (csHigh) begin
      state_next  = SSC_ST_IDLE;
      bitCnt_next = 5'h00;
      outCnt_next = 4'h0;
      oeHigh_next = 1'b0;
      oeLow_next  = 1'b0;
    end else begin
      case (state_reg)
        // only a select fall starts a command
        SSC_ST_IDLE: begin
          state_next = SSC_ST_CMD;
        end
        SSC_ST_CMD: begin
          if (sckRise) begin
            shift_next  = shiftIn;
            bitCnt_next = bitsNext;
            if (bitsNext == SSC_INSTR_BITS) begin
              bitCnt_next = 5'h00;
              case (shiftIn[7:0])
                SSC_READ_CMD: begin
                  op_next    = SSC_OP_ARR_RD;
                  state_next = SSC_ST_ADDR;
                end
                SSC_WRITE_CMD: begin
                  op_next    = SSC_OP_ARR_WR;
                  state_next = SSC_ST_ADDR;
                end
                SSC_MODE_READ_CMD: begin
                  op_next    = SSC_OP_MODE_RD;
                  state_next = SSC_ST_XFER;
                end
                SSC_MODE_WRITE_CMD: begin
                  op_next    = SSC_OP_MODE_WR;
                  state_next = SSC_ST_XFER;
                end
                SSC_ENTER_WIDE_CMD: begin
                  wide_next  = 1'b1;
                  state_next = SSC_ST_DONE;
                end
                // accepted at the width in force
                SSC_LEAVE_WIDE_CMD: begin
                  wide_next  = 1'b0;
                  state_next = SSC_ST_DONE;
                end
                default: begin
                  state_next = SSC_ST_DONE;
                end
              endcase
            end
          end
        end
        SSC_ST_ADDR: begin
          if (sckRise) begin
            shift_next  = shiftIn;
            bitCnt_next = bitsNext;
            if (bitsNext == SSC_ADDR_CNT) begin
              bitCnt_next = 5'h00;
              addr_next   = shiftIn[ADDR_W-1:0];
              state_next  = SSC_ST_XFER;
            end
          end
        end
        SSC_ST_XFER: begin
          if (sckRise && isWrite) begin
            shift_next  = shiftIn;
            bitCnt_next = bitsNext;
            if (bitsNext == SSC_DATA_CNT) begin
              bitCnt_next = 5'h00;
              if (op_reg == SSC_OP_ARR_WR) begin
                memWe     = 1'b1;
                addr_next = nextAddr(addr_reg, mode_reg);
                if (mode_reg == SSC_MODE_BYTE) begin
                  state_next = SSC_ST_DONE;
                end
              end else begin
                if (shiftIn[SSC_MODE_MSB:SSC_MODE_LSB] != SSC_MODE_RSVD) begin
                  mode_next = shiftIn[SSC_MODE_MSB:SSC_MODE_LSB];
                end
                state_next = SSC_ST_DONE;
              end
            end
          end
          if (sckFall && isRead) begin
            oeHigh_next  = 1'b1;
            oeLow_next   = wide_reg;
            outHigh_next = byteNow[7];
            if (wide_reg) begin
              outLow_next   = byteNow[6];
              outShift_next = {byteNow[5:0], 2'h0};
            end else begin
              outShift_next = {byteNow[6:0], 1'h0};
            end
            outCnt_next = outNext;
            if (outNext == SSC_OUT_BITS) begin
              outCnt_next = 4'h0;
              if (op_reg == SSC_OP_ARR_RD) begin
                addr_next = nextAddr(addr_reg, mode_reg);
              end
              if ((op_reg == SSC_OP_MODE_RD) || (mode_reg == SSC_MODE_BYTE)) begin
                state_next = SSC_ST_DONE;
              end
            end
          end
        end
        // Last bit stays on the line until deselect; unknown commands never drove
        SSC_ST_DONE: begin
          state_next = SSC_ST_DONE;
        end
        default: begin
          state_next = SSC_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg    <= SSC_ST_IDLE;
      op_reg       <= SSC_OP_ARR_RD;
      shift_reg    <= 16'h0000;
      bitCnt_reg   <= 5'h00;
      addr_reg     <= '0;
      mode_reg     <= SSC_MODE_RESET;
      wide_reg     <= 1'b0;
      outShift_reg <= 8'h00;
      outCnt_reg   <= 4'h0;
      outHigh_reg  <= 1'b0;
      outLow_reg   <= 1'b0;
      oeHigh_reg   <= 1'b0;
      oeLow_reg    <= 1'b0;
    end else begin
      state_reg    <= state_next;
      op_reg       <= op_next;
      shift_reg    <= shift_next;
      bitCnt_reg   <= bitCnt_next;
      addr_reg     <= addr_next;
      mode_reg     <= mode_next;
      wide_reg     <= wide_next;
      outShift_reg <= outShift_next;
      outCnt_reg   <= outCnt_next;
      outHigh_reg  <= outHigh_next;
      outLow_reg   <= outLow_next;
      oeHigh_reg   <= oeHigh_next;
      oeLow_reg    <= oeLow_next;
    end
  end

  assign dualLineHighOut = outHigh_reg;
  assign dualLineLowOut  = outLow_reg;
  assign dualLineHighOe  = oeHigh_reg;
  assign dualLineLowOe   = oeLow_reg;
  assign standby         = csHigh && (state_reg == SSC_ST_IDLE);
  assign twoBitMode      = wide_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence instrEnds;
    (state_reg == SSC_ST_CMD) && sckRise && (bitsNext == SSC_INSTR_BITS) && !csHigh;
  endsequence

  sequence byteWritten;
    memWe && (mode_reg == SSC_MODE_BYTE);
  endsequence

  deselect_release_a: assert property (
    csHigh && $past(csHigh) |-> !dualLineHighOe && !dualLineLowOe)
    else $error("Data lines driven while deselected");

  out_after_fall_a: assert property (
    !$stable(dualLineHighOut) |-> $past(sckFall))
    else $error("Output changed without a serial clock fall");

  instr_capture_a: assert property (
    (state_reg == SSC_ST_CMD) && sckRise && !wide_reg && !csHigh
      |=> shift_reg[0] == $past(pinLvl[SSC_LOW_PIN]))
    else $error("Instruction bit not captured on rise");

  enter_wide_a: assert property (
    instrEnds ##0 (shiftIn[7:0] == SSC_ENTER_WIDE_CMD) |=> wide_reg && (state_reg == SSC_ST_DONE))
    else $error("Enter wide command not taken");

  read_decode_a: assert property (
    instrEnds ##0 (shiftIn[7:0] == SSC_READ_CMD)
      |=> (state_reg == SSC_ST_ADDR) && (op_reg == SSC_OP_ARR_RD))
    else $error("Read command not decoded");

  unknown_cmd_a: assert property (
    (state_reg == SSC_ST_DONE) && !oeHigh_reg && !csHigh
      |=> !oeHigh_reg && !oeLow_reg && !memWe)
    else $error("Ignored command drove or wrote");

  mode_valid_a: assert property (
    mode_reg != SSC_MODE_RSVD)
    else $error("Reserved addressing mode held");

  byte_single_a: assert property (
    byteWritten |=> (state_reg == SSC_ST_DONE) && !memWe)
    else $error("Byte mode went past one byte");

  page_wrap_a: assert property (
    memWe && (mode_reg == SSC_MODE_PAGE) && (&addr_reg[SSC_PAGE_BITS-1:0]) && !csHigh
      |=> (addr_reg[SSC_PAGE_BITS-1:0] == '0)
          && (addr_reg[ADDR_W-1:SSC_PAGE_BITS] == $past(addr_reg[ADDR_W-1:SSC_PAGE_BITS])))
    else $error("Page address did not wrap to page start");

  seq_roll_a: assert property (
    memWe && (mode_reg == SSC_MODE_SEQ) && (&addr_reg) && !csHigh |=> addr_reg == '0)
    else $error("Sequential address did not roll over");

  mode_read_zero_a: assert property (
    sckFall && (state_reg == SSC_ST_XFER) && (op_reg == SSC_OP_MODE_RD) && !wide_reg
      && (outCnt_reg >= 4'h2) && !csHigh |=> dualLineHighOut == 1'b0)
    else $error("Reserved mode bit read as one");
endmodule

/* File: hdl/ssc_mem.sv */
// Byte-wide storage array held in flip-flops, one shared address.
// Assumes writes are single-cycle strobes on ref_clk; reads are combinational.
`timescale 1ns/1ps
module ssc_mem #(
  parameter int ADDR_W = 16
) (
  input  wire logic              ref_clk,  // Core clock
  input  wire logic              wrEn,     // Write strobe
  input  wire logic [ADDR_W-1:0] addr,     // Byte address
  input  wire logic [7:0]        wrData,   // Byte to store
  output logic      [7:0]        rdData    // Byte at addr
);
  logic [7:0] cell_reg [2**ADDR_W];

  // Contents survive reset on purpose, as a static memory would
  always_ff @(posedge ref_clk) begin
    if (wrEn) begin
      cell_reg[addr] <= wrData;
    end
  end

  assign rdData = cell_reg[addr];
endmodule

/* File: hdl/ssc_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter and edge pulses.
// Assumes asynchronous pin levels; outputs are on ref_clk.
`timescale 1ns/1ps
module ssc_pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             ref_clk,   // Core clock
  input  wire logic             reset_n,   // Async reset, active low
  input  wire logic [WIDTH-1:0] pinIn,     // Raw pin levels
  input  wire logic [WIDTH-1:0] pinReset,  // Pins whose rise pulse is masked
  output logic      [WIDTH-1:0] level,     // Filtered level
  output logic      [WIDTH-1:0] rise,      // One-cycle rise pulse
  output logic      [WIDTH-1:0] fall       // One-cycle fall pulse
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] level_next;

  // A change counts only when stages two and three agree
  always_comb begin
    level_next = level_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2_reg[i] == stage3_reg[i]) begin
        level_next[i] = stage3_reg[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_reg <= '1;
      stage2_reg <= '1;
      stage3_reg <= '1;
      level_reg  <= '1;
    end else begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      level_reg  <= level_next;
    end
  end

  assign level = level_reg;
  assign rise  = level_next & ~level_reg & ~pinReset;
  assign fall  = ~level_next & level_reg;
endmodule

/* File: inc/ssc_pkg.sv */
// Constants, encodings and state types for the serial static memory front end.
// Assumes every user works on the ref_clk domain and imports the whole package.

package ssc_pkg;

  localparam int           SSC_ADDR_BITS      = 16;
  localparam int           SSC_PAGE_BITS      = 5;
  localparam int           SSC_MODE_MSB       = 7;
  localparam int           SSC_MODE_LSB       = 6;
  localparam int           SSC_PIN_COUNT      = 4;

  localparam logic [4:0]   SSC_INSTR_BITS     = 5'h08;
  localparam logic [4:0]   SSC_ADDR_CNT       = 5'h10;
  localparam logic [4:0]   SSC_DATA_CNT       = 5'h08;
  localparam logic [3:0]   SSC_OUT_BITS       = 4'h8;

  localparam logic [7:0]   SSC_READ_CMD       = 8'h03;
  localparam logic [7:0]   SSC_WRITE_CMD      = 8'h02;
  localparam logic [7:0]   SSC_MODE_READ_CMD  = 8'h05;
  localparam logic [7:0]   SSC_MODE_WRITE_CMD = 8'h01;
  localparam logic [7:0]   SSC_ENTER_WIDE_CMD = 8'h3B;
  localparam logic [7:0]   SSC_LEAVE_WIDE_CMD = 8'hFF;

  localparam logic [1:0]   SSC_MODE_BYTE      = 2'h0;
  localparam logic [1:0]   SSC_MODE_PAGE      = 2'h2;
  localparam logic [1:0]   SSC_MODE_SEQ       = 2'h1;
  localparam logic [1:0]   SSC_MODE_RSVD      = 2'h3;
  localparam logic [1:0]   SSC_MODE_RESET     = SSC_MODE_SEQ;
  localparam logic [5:0]   SSC_MODE_LOW_BITS  = 6'h00;

  localparam int           SSC_CS_PIN         = 0;
  localparam int           SSC_SCK_PIN        = 1;
  localparam int           SSC_LOW_PIN        = 2;
  localparam int           SSC_HIGH_PIN       = 3;

  typedef enum logic [2:0] {
    SSC_ST_IDLE = 3'h0,
    SSC_ST_CMD  = 3'h1,
    SSC_ST_ADDR = 3'h3,
    SSC_ST_XFER = 3'h2,
    SSC_ST_DONE = 3'h6
  } ssc_state_t;

  typedef enum logic [1:0] {
    SSC_OP_ARR_RD  = 2'h0,
    SSC_OP_ARR_WR  = 2'h1,
    SSC_OP_MODE_RD = 2'h2,
    SSC_OP_MODE_WR = 2'h3
  } ssc_op_t;

endpackage

/* File: tb/ssc_master_model.sv */
// Behavioural serial bus master for the memory front end: select, clock, data.
// Assumes the bench resolves both shared data lines and feeds them back here.
`timescale 1ns/1ps
module ssc_master_model
  import ssc_pkg::*;
(
  input  wire logic ref_clk,     // Core clock
  input  wire logic lowLine,     // Resolved low data line
  input  wire logic highLine,    // Resolved high data line
  output logic      chipSelectN, // Select, active low
  output logic      serialClk,   // Serial clock, idle low
  output logic      lowDrv,      // Master level on low line
  output logic      lowOe,       // Master drives low line
  output logic      highDrv,     // Master level on high line
  output logic      highOe,      // Master drives high line
  output logic      skewSeen     // Read data moved while clock high
);
  logic wide;

  initial begin
    chipSelectN = 1'b1;
    serialClk   = 1'b0;
    lowDrv      = 1'b0;
    lowOe       = 1'b0;
    highDrv     = 1'b0;
    highOe      = 1'b0;
    skewSeen    = 1'b0;
    wide        = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // two bits per clock when wide, upper on high line; otherwise one bit out on low line and one bit in on high line
  // Data is sampled late in the high phase: the device answers several core clocks after the fall
  task automatic clk_bits(input logic [1:0] tx, input logic drv, output logic [1:0] rx);
    logic [1:0] early;
    lowDrv    = tx[0];
    highDrv   = tx[1];
    lowOe     = drv || !wide;
    highOe    = drv && wide;
    tick(4);
    serialClk = 1'b1;
    tick(1);
    early     = {highLine, lowLine};
    tick(3);
    rx        = {highLine, lowLine};
    if (!drv && rx !== early) begin
      skewSeen = 1'b1;
    end
    serialClk = 1'b0;
  endtask

  task automatic xbyte(input logic [7:0] tx, input logic drv, output logic [7:0] rx);
    logic [7:0] s;
    logic [1:0] b;
    s = tx;
    repeat (wide ? 4 : 8) begin
      clk_bits(wide ? s[7:6] : {1'b0, s[7]}, drv, b);
      s  = wide ? {s[5:0], 2'b00} : {s[6:0], 1'b0};
      rx = wide ? {rx[5:0], b} : {rx[6:0], b[1]};
    end
  endtask

  // select held low, sent at current width
  task automatic txn(input logic [7:0] op, input logic [15:0] adr, input int n,
                     input logic [7:0] wd [4], output logic [7:0] rd [4]);
    logic [7:0] junk;
    logic       rdOp;
    rdOp        = (op == SSC_READ_CMD) || (op == SSC_MODE_READ_CMD);
    chipSelectN = 1'b0;
    tick(4);
    xbyte(op, 1'b1, junk);
    if (op == SSC_READ_CMD || op == SSC_WRITE_CMD) begin
      xbyte(adr[15:8], 1'b1, junk);
      xbyte(adr[7:0], 1'b1, junk);
    end
    for (int k = 0; k < n; k++) begin
      xbyte(wd[k], !rdOp, rd[k]);
    end
    lowOe       = 1'b0;
    highOe      = 1'b0;
    chipSelectN = 1'b1;
    if (op == SSC_ENTER_WIDE_CMD) begin
      wide = 1'b1;
    end
    if (op == SSC_LEAVE_WIDE_CMD) begin
      wide = 1'b0;
    end
    tick(8);
  endtask
endmodule

/* File: tb/tb_ssc_core.sv */
// Self-checking bench for the serial memory front end, driven by a master model.
// Assumes the package constants; undriven data lines show a changing level.
`timescale 1ns/1ps
module tb_ssc_core;
  import ssc_pkg::*;
  logic       ref_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       filler  = 1'b0;
  logic       oeSeen  = 1'b0;
  logic       chipSelectN, serialClk, lowLine, highLine;
  logic       mLowDrv, mLowOe, mHighDrv, mHighOe, skewSeen;
  logic       dutLowOut, dutLowOe, dutHighOut, dutHighOe, standby, twoBitMode;
  int         error_cnt   = 0;
  int         checks_done = 0;
  int         cycles      = 0;
  logic [7:0] wd [4];
  logic [7:0] rd [4];

  always #4 ref_clk = ~ref_clk;

  // Nobody driving shows a level that flips every cycle, never a stale bit
  assign lowLine  = dutLowOe ? dutLowOut : (mLowOe ? mLowDrv : filler);
  assign highLine = dutHighOe ? dutHighOut : (mHighOe ? mHighDrv : filler);

  always @(posedge ref_clk) begin
    filler <= ~filler;
    cycles <= cycles + 1;
    if (dutLowOe || dutHighOe) begin
      oeSeen <= 1'b1;
    end
    if (cycles == 40000) begin
      error_cnt++;
      end_of_test();
    end
  end

  ssc_master_model u_master (
    .ref_clk(ref_clk), .lowLine(lowLine), .highLine(highLine), .chipSelectN(chipSelectN),
    .serialClk(serialClk), .lowDrv(mLowDrv), .lowOe(mLowOe), .highDrv(mHighDrv),
    .highOe(mHighOe), .skewSeen(skewSeen));

  ssc_core u_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .chipSelectN(chipSelectN), .serialClk(serialClk),
    .dualLineLowIn(lowLine), .dualLineLowOut(dutLowOut), .dualLineLowOe(dutLowOe),
    .dualLineHighIn(highLine), .dualLineHighOut(dutHighOut), .dualLineHighOe(dutHighOe),
    .standby(standby), .twoBitMode(twoBitMode));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic set_mode(input logic [7:0] m);
    wd[0] = m;
    u_master.txn(SSC_MODE_WRITE_CMD, 16'h0000, 1, wd, rd);
  endtask

  task automatic rd_arr(input logic [15:0] a, input int n);
    u_master.txn(SSC_READ_CMD, a, n, wd, rd);
  endtask

  initial begin
    wd = '{default: 8'h00};
    repeat (5) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    u_master.tick(4);
    check({7'h00, standby}, 8'h01);
    check({7'h00, dutHighOe}, 8'h00);
    u_master.txn(SSC_MODE_READ_CMD, 16'h0000, 1, wd, rd);
    check(rd[0], 8'h40);
    wd = '{8'hA1, 8'hB2, 8'hC3, 8'h00};
    u_master.txn(SSC_WRITE_CMD, 16'hFFFF, 3, wd, rd);
    rd_arr(16'hFFFF, 3);
    check(rd[0], 8'hA1);
    check(rd[1], 8'hB2);
    check(rd[2], 8'hC3);
    set_mode(8'h80);
    u_master.txn(SSC_MODE_READ_CMD, 16'h0000, 1, wd, rd);
    check(rd[0], 8'h80);
    set_mode(8'hC0);
    u_master.txn(SSC_MODE_READ_CMD, 16'h0000, 1, wd, rd);
    check(rd[0], 8'h80);
    // Page 0x20-0x3F: the third byte wraps to 0x20
    wd = '{8'h11, 8'h22, 8'h33, 8'h00};
    u_master.txn(SSC_WRITE_CMD, 16'h003E, 3, wd, rd);
    rd_arr(16'h003F, 2);
    check(rd[0], 8'h22);
    check(rd[1], 8'h33);
    set_mode(8'h00);
    wd[0] = 8'h5A;
    u_master.txn(SSC_WRITE_CMD, 16'h0101, 1, wd, rd);
    wd = '{8'h66, 8'h77, 8'h00, 8'h00};
    u_master.txn(SSC_WRITE_CMD, 16'h0100, 2, wd, rd);
    rd_arr(16'h0100, 2);
    check(rd[0], 8'h66);
    check(rd[1], 8'h00);
    rd_arr(16'h0101, 1);
    check(rd[0], 8'h5A);
    set_mode(8'h40);
    oeSeen = 1'b0;
    wd = '{SSC_WRITE_CMD, 8'hFF, 8'hFF, 8'hEE};
    u_master.txn(8'h77, 16'h0000, 4, wd, rd);
    check({7'h00, oeSeen}, 8'h00);
    check({7'h00, standby}, 8'h01);
    rd_arr(16'hFFFF, 1);
    check(rd[0], 8'hA1);
    u_master.txn(SSC_ENTER_WIDE_CMD, 16'h0000, 0, wd, rd);
    check({7'h00, twoBitMode}, 8'h01);
    wd = '{8'hC3, 8'h3C, 8'h00, 8'h00};
    u_master.txn(SSC_WRITE_CMD, 16'h0200, 2, wd, rd);
    rd_arr(16'h0200, 2);
    check(rd[0], 8'hC3);
    check(rd[1], 8'h3C);
    u_master.txn(SSC_LEAVE_WIDE_CMD, 16'h0000, 0, wd, rd);
    check({7'h00, twoBitMode}, 8'h00);
    rd_arr(16'h0201, 1);
    check(rd[0], 8'h3C);
    check({7'h00, skewSeen}, 8'h00);
    end_of_test();
  end
endmodule
